// *** common/tcs_pkg.sv ***
package tcs_pkg;
  // clock and timing
  localparam int CLK_HZ = 25000000;
  localparam int JOB_TIME_S = 10;
  localparam int ZERO_WINDOW_MIN = 5;
  localparam longint JOB_CYCLES = longint'(JOB_TIME_S) * CLK_HZ;
  localparam longint ZERO_WINDOW_CYCLES = longint'(ZERO_WINDOW_MIN) * 60 * CLK_HZ;
  localparam int LED_MS = 250;
  localparam int LED_CYCLES = LED_MS * (CLK_HZ / 1000);
  localparam int GAP_SLOTS = 4;
  localparam int GREEN_DIV = 20;
  localparam int YELLOW_HOLD = 1000;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_SVC = 8'h10;
  localparam logic [7:0] OFS_SVC_RESULT = 8'h14;
  localparam logic [7:0] OFS_PASSWORD = 8'h18;
  localparam logic [7:0] OFS_DCC_MIN = 8'h1c;

  // ctrl bits
  localparam int CTRL_ZERO = 0;
  localparam int CTRL_SPAN = 1;
  localparam int CTRL_RESTORE = 2;
  localparam int CTRL_COEFF = 3;

  // irq event bits
  localparam int EV_ZERO_DONE = 0;
  localparam int EV_SPAN_DONE = 1;
  localparam int EV_RESTORE_DONE = 2;
  localparam int EV_REFUSED = 3;
  localparam int EV_SVC = 4;
  localparam int EV_ADDR_CHG = 5;
  localparam int NUM_EV = 6;

  // service request codes
  localparam logic [1:0] SVC_NONE = 2'h0;
  localparam logic [1:0] SVC_DCC = 2'h1;
  localparam logic [1:0] SVC_REINIT = 2'h2;
  localparam logic [2:0] RD_COLD = 3'h0;
  localparam logic [2:0] RD_WARM = 3'h1;
  localparam logic [31:0] PASSWORD_RST = 32'h0000_5a5a; // arbitrary value
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'h7f;
  localparam logic [7:0] ADDR_SHIPPED = 8'h7f;

  typedef enum logic [2:0] {RED_OFF, RED_SOLID, RED_ONE, RED_TWO, RED_THREE} tcs_red_t;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } tcs_led_t;

  typedef struct packed {
    logic zero_flag;
    logic span_flag;
    logic restore_flag;
    logic coeff_sel;
    logic zero_valid;
    logic restore_busy;
    logic dcc_disabled;
    logic reinit_cold;
    logic reinit_warm;
  } tcs_out_t;
endpackage

// *** hdl/tcs_top.sv ***
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// (R1) writing one to span flag starts span adjust at applied full-range pressure
// (R2) span accepted only after good zero within last five minutes
// (R3) refused span request drops span flag back to zero
// (R4) span finishes within ten seconds; flag still set means success
// (R5) factory restore returns zero, span, k, area, coefficient select to defaults
// (R6) restore finishes within ten seconds; flag still set means success
// (R7) communication control runs only with correct password, optional minutes duration; minutes are stored but nothing counts them
// (R8) reinitialize accepts cold or warm start with password, else error
// (R9) green led shows sensor traffic, flashing fast in normal operation
// (R10) yellow led lights only for frames addressed to this node
// (R11) red led solid while factory configuration is invalid
// (R12) red bursts: one bad address, two baud detect, three sensor fail
// (R13) node address is weighted sum of switch positions, first weighs 128
// (R14) only addresses one through 127 are valid, others flag error
// (R15) shipped switch setting decodes address 127
// (R16) zero succeeds only inside band around previous zero, within ten seconds
// (R17) baud detection restarts on power up and address change
// (R18) red shows only highest priority error, solid first, then fewer flashes
module tcs_top #(
  parameter longint JOB_LIMIT = tcs_pkg::JOB_CYCLES,
  parameter longint ZERO_WINDOW = tcs_pkg::ZERO_WINDOW_CYCLES,
  parameter int LED_SLOT = tcs_pkg::LED_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] address_switch_bank,
  input wire logic pressure_in_band,
  input wire logic cal_engine_done,
  input wire logic factory_cfg_valid,
  input wire logic baud_locked,
  input wire logic sensor_link_ok,
  input wire logic sensor_xfer,
  input wire logic frame_for_me,
  output logic baud_restart,
  output tcs_pkg::tcs_led_t leds,
  output tcs_pkg::tcs_out_t ctl,
  output logic irq
);
  import tcs_pkg::*;

  typedef enum logic [1:0] {JOB_IDLE, JOB_ZERO, JOB_SPAN, JOB_RESTORE} tcs_job_t;

  tcs_job_t job_reg, job_next;
  logic [35:0] job_cnt_reg, job_cnt_next;
  logic [35:0] zero_age_reg, zero_age_next;
  logic zero_ok_reg, zero_ok_next;
  logic zf_reg, zf_next, sf_reg, sf_next, rf_reg, rf_next, coeff_reg, coeff_next;
  logic [NUM_EV-1:0] ev;
  logic [3:0] job_ev;
  logic svc_ev;
  logic [NUM_EV-1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [31:0] pw_reg, pw_next, dcc_min_reg, dcc_min_next;
  logic [2:0] svc_res_reg, svc_res_next;
  logic dcc_dis_reg, dcc_dis_next, cold_reg, cold_next, warm_reg, warm_next;
  logic [31:0] prdata_next;
  logic pslverr_next, pready_next;
  logic [7:0] node_addr, addr_reg;
  logic addr_bad, addr_chg;
  logic wr, rd;
  tcs_red_t red_mode;
  logic [31:0] slot_reg, slot_next;
  logic [3:0] phase_reg, phase_next;
  logic [4:0] gdiv_reg, gdiv_next;
  logic [9:0] yhold_reg, yhold_next;
  tcs_led_t leds_next;
  logic irq_next, brst_next;
  logic red_on;

  // apb access phase; zero wait states so pready rises with penable
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && pready;

  // switch decode: position 1 is msb, weight 128 down to 1
  assign node_addr = address_switch_bank; // (R13)
  assign addr_bad = (node_addr < ADDR_MIN) || (node_addr > ADDR_MAX); // (R14)
  assign addr_chg = node_addr != addr_reg; // (R17)

  // calibration jobs and trigger flags
  always_comb begin
    job_next = job_reg;
    job_cnt_next = job_cnt_reg;
    zf_next = zf_reg;
    sf_next = sf_reg;
    rf_next = rf_reg;
    coeff_next = coeff_reg;
    zero_ok_next = zero_ok_reg;
    zero_age_next = zero_age_reg;
    job_ev[EV_ZERO_DONE] = 1'b0;
    job_ev[EV_SPAN_DONE] = 1'b0;
    job_ev[EV_RESTORE_DONE] = 1'b0;
    job_ev[EV_REFUSED] = 1'b0;
    // zero age expires the span window
    if (zero_ok_reg) begin
      if (zero_age_reg >= 36'(ZERO_WINDOW - 1)) begin
        zero_ok_next = 1'b0; // (R2)
      end else begin
        zero_age_next = zero_age_reg + 36'h1;
      end
    end
    if (wr && paddr == OFS_CTRL) begin
      coeff_next = pwdata[CTRL_COEFF];
    end
    case (job_reg)
      JOB_IDLE: begin
        job_cnt_next = '0;
        if (wr && paddr == OFS_CTRL && pwdata[CTRL_RESTORE]) begin
          rf_next = 1'b1; // (R5)
          job_next = JOB_RESTORE;
        end else if (wr && paddr == OFS_CTRL && pwdata[CTRL_SPAN]) begin
          if (zero_ok_reg) begin
            sf_next = 1'b1; // (R1)
            job_next = JOB_SPAN;
          end else begin
            sf_next = 1'b0; // (R3)
            job_ev[EV_REFUSED] = 1'b1;
          end
        end else if (wr && paddr == OFS_CTRL && pwdata[CTRL_ZERO]) begin
          if (pressure_in_band) begin
            zf_next = 1'b1;
            job_next = JOB_ZERO;
          end else begin
            zf_next = 1'b0; // (R16)
            job_ev[EV_REFUSED] = 1'b1;
          end
        end
      end
      default: begin
        // finish on engine done or forced at the time limit
        if (cal_engine_done || job_cnt_reg >= 36'(JOB_LIMIT - 1)) begin // (R4) (R6)
          job_next = JOB_IDLE;
          if (job_reg == JOB_ZERO) begin
            job_ev[EV_ZERO_DONE] = 1'b1;
            zero_ok_next = 1'b1; // (R16)
            zero_age_next = '0;
          end else if (job_reg == JOB_SPAN) begin
            job_ev[EV_SPAN_DONE] = 1'b1;
          end else begin
            job_ev[EV_RESTORE_DONE] = 1'b1;
            coeff_next = 1'b0; // (R5)
            zero_ok_next = 1'b0;
          end
        end else begin
          job_cnt_next = job_cnt_reg + 36'h1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job_reg <= JOB_IDLE;
      job_cnt_reg <= '0;
      zf_reg <= 1'b0;
      sf_reg <= 1'b0;
      rf_reg <= 1'b0;
      coeff_reg <= 1'b0;
      zero_ok_reg <= 1'b0;
      zero_age_reg <= '0;
    end else begin
      job_reg <= job_next;
      job_cnt_reg <= job_cnt_next;
      zf_reg <= zf_next;
      sf_reg <= sf_next;
      rf_reg <= rf_next;
      coeff_reg <= coeff_next;
      zero_ok_reg <= zero_ok_next;
      zero_age_reg <= zero_age_next;
    end
  end

  // services: password-checked dcc and reinit
  always_comb begin
    svc_res_next = svc_res_reg;
    dcc_dis_next = dcc_dis_reg;
    cold_next = 1'b0;
    warm_next = 1'b0;
    pw_next = pw_reg;
    dcc_min_next = dcc_min_reg;
    svc_ev = 1'b0;
    if (wr && paddr == OFS_PASSWORD) begin
      pw_next = pwdata;
    end
    if (wr && paddr == OFS_DCC_MIN) begin
      dcc_min_next = pwdata;
    end
    if (wr && paddr == OFS_SVC) begin
      svc_ev = 1'b1;
      svc_res_next = 3'h4; // error unless accepted below
      if (pwdata[31:0] != 32'h0 && pwdata[1:0] == SVC_DCC && pw_reg == PASSWORD_RST) begin
        dcc_dis_next = pwdata[4]; // (R7)
        svc_res_next = 3'h1;
      end else if (pwdata[1:0] == SVC_REINIT && pw_reg == PASSWORD_RST) begin
        if (pwdata[10:8] == RD_COLD) begin
          cold_next = 1'b1; // (R8)
          svc_res_next = 3'h2;
        end else if (pwdata[10:8] == RD_WARM) begin
          warm_next = 1'b1; // (R8)
          svc_res_next = 3'h2;
        end
      end
    end
    // timed disable clears on a write to the minutes register while it holds zero; nothing here counts minutes
    if (dcc_dis_reg && dcc_min_reg == 32'h0 && wr && paddr == OFS_DCC_MIN) begin
      dcc_dis_next = 1'b0; // (R7)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_res_reg <= '0;
      dcc_dis_reg <= 1'b0;
      cold_reg <= 1'b0;
      warm_reg <= 1'b0;
      pw_reg <= '0;
      dcc_min_reg <= '0;
    end else begin
      svc_res_reg <= svc_res_next;
      dcc_dis_reg <= dcc_dis_next;
      cold_reg <= cold_next;
      warm_reg <= warm_next;
      pw_reg <= pw_next;
      dcc_min_reg <= dcc_min_next;
    end
  end

  // red priority: solid, then fewest flashes
  always_comb begin
    if (!factory_cfg_valid) begin
      red_mode = RED_SOLID; // (R11) (R18)
    end else if (addr_bad) begin
      red_mode = RED_ONE; // (R12)
    end else if (!baud_locked || brst_next) begin
      red_mode = RED_TWO; // (R17)
    end else if (!sensor_link_ok) begin
      red_mode = RED_THREE;
    end else begin
      red_mode = RED_OFF;
    end
  end

  // burst: phases 0..2n-1 alternate on/off, then dark up to phase 6+GAP_SLOTS-1
  always_comb begin
    slot_next = slot_reg + 32'h1;
    phase_next = phase_reg;
    if (slot_reg >= 32'(LED_SLOT - 1)) begin
      slot_next = '0;
      phase_next = (phase_reg >= 4'(6 + GAP_SLOTS - 1)) ? 4'h0 : phase_reg + 4'h1;
    end
    case (red_mode)
      RED_SOLID: red_on = 1'b1;
      RED_ONE: red_on = (phase_reg < 4'h2) && !phase_reg[0];
      RED_TWO: red_on = (phase_reg < 4'h4) && !phase_reg[0];
      RED_THREE: red_on = (phase_reg < 4'h6) && !phase_reg[0];
      default: red_on = 1'b0;
    endcase
    gdiv_next = sensor_xfer ? gdiv_reg + 5'h1 : gdiv_reg;
    yhold_next = frame_for_me ? 10'(YELLOW_HOLD) : (yhold_reg != 10'h0 ? yhold_reg - 10'h1 : yhold_reg);
    leds_next.green = gdiv_reg[4]; // (R9)
    leds_next.yellow = yhold_reg != 10'h0; // (R10)
    leds_next.red = red_on; // (R12)
    brst_next = addr_chg;
  end

  // interrupt status: set wins over write-one-to-clear
  assign ev = {addr_chg, svc_ev, job_ev}; // one driver; order follows the event bit positions
  always_comb begin
    ist_next = ist_reg;
    imask_next = imask_reg;
    if (wr && paddr == OFS_IRQ_STAT) begin
      ist_next = ist_reg & ~pwdata[NUM_EV-1:0];
    end
    ist_next = ist_next | ev;
    if (wr && paddr == OFS_IRQ_MASK) begin
      imask_next = pwdata[NUM_EV-1:0];
    end
    irq_next = |(ist_next & imask_next);
  end

  // apb read mux and error on unmapped offsets
  always_comb begin
    prdata_next = '0;
    pslverr_next = 1'b0;
    pready_next = psel && !penable;
    if (psel && !penable) begin
      if (paddr == OFS_CTRL) begin
        prdata_next = {28'h0, coeff_reg, rf_reg, sf_reg, zf_reg};
      end else if (paddr == OFS_STATUS) begin
        prdata_next = {13'h0, addr_bad, addr_reg, 2'(job_reg), 1'b0, zero_ok_reg, baud_locked, dcc_dis_reg, 4'h0};
      end else if (paddr == OFS_IRQ_STAT) begin
        prdata_next = 32'(ist_reg);
      end else if (paddr == OFS_IRQ_MASK) begin
        prdata_next = 32'(imask_reg);
      end else if (paddr == OFS_SVC_RESULT) begin
        prdata_next = 32'(svc_res_reg);
      end else if (paddr == OFS_DCC_MIN) begin
        prdata_next = dcc_min_reg;
      end else if (paddr == OFS_SVC || paddr == OFS_PASSWORD) begin
        prdata_next = '0;
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_reg <= '0;
      imask_reg <= '0;
      irq <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      slot_reg <= '0;
      phase_reg <= '0;
      gdiv_reg <= '0;
      yhold_reg <= '0;
      leds <= '0;
      addr_reg <= ADDR_SHIPPED; // (R15)
      baud_restart <= 1'b1; // (R17)
    end else begin
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      irq <= irq_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      slot_reg <= slot_next;
      phase_reg <= phase_next;
      gdiv_reg <= gdiv_next;
      yhold_reg <= yhold_next;
      leds <= leds_next;
      addr_reg <= node_addr;
      baud_restart <= brst_next; // (R17)
    end
  end

  // control outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= '0;
    end else begin
      ctl <= '{zero_flag: zf_next, span_flag: sf_next, restore_flag: rf_next, coeff_sel: coeff_next,
               zero_valid: zero_ok_next, restore_busy: job_next == JOB_RESTORE,
               dcc_disabled: dcc_dis_next, reinit_cold: cold_next, reinit_warm: warm_next};
    end
  end

  AST_SPAN_REFUSED: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFS_CTRL && pwdata[CTRL_SPAN] && !pwdata[CTRL_RESTORE] && job_reg == JOB_IDLE && !zero_ok_reg)
    |=> !ctl.span_flag) else $error("span accepted without valid zero"); // (R3)
  AST_SPAN_NEEDS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (job_next == JOB_SPAN && job_reg == JOB_IDLE) |-> zero_ok_reg) else $error("span started without zero"); // (R2)
  AST_JOB_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    job_cnt_reg <= 36'(JOB_LIMIT)) else $error("job ran past its limit"); // (R4)
  AST_RED_SOLID: assert property (@(posedge pclk) disable iff (!presetn)
    !factory_cfg_valid ##1 !factory_cfg_valid |-> leds.red) else $error("red not solid"); // (R11)
  AST_ADDR_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    (node_addr == 8'h00 || node_addr[7]) |-> addr_bad) else $error("bad address missed"); // (R14)
  AST_YELLOW_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (yhold_reg == 10'h0 && !frame_for_me) |=> !leds.yellow) else $error("yellow without frame"); // (R10)
  AST_BAUD_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    addr_chg |=> baud_restart) else $error("no baud restart on address change"); // (R17)
  AST_REINIT_PW: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl.reinit_cold || ctl.reinit_warm) |-> $past(pw_reg) == PASSWORD_RST) else $error("reinit without password"); // (R8)
  COV_SPAN_OK: cover property (@(posedge pclk) job_reg == JOB_SPAN ##1 job_reg == JOB_IDLE);
  COV_RESTORE: cover property (@(posedge pclk) job_reg == JOB_RESTORE);
  COV_REFUSE: cover property (@(posedge pclk) ev[EV_REFUSED]);
endmodule

// *** verification/tcs_far_model.sv ***
`timescale 1ns/1ps
// stand-in for calibration engine, sensor port and baud detector
module tcs_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] job,
  input wire logic slow,
  input wire logic baud_restart,
  output logic cal_engine_done,
  output logic sensor_xfer,
  output logic baud_locked
);
  logic [2:0] job_q;
  logic [3:0] job_cnt;
  logic [3:0] lock_cnt;
  logic [2:0] xfer_cnt;
  // slow engine never answers, so the block's own limit must end the job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job_q <= 3'h0;
      job_cnt <= 4'h0;
      cal_engine_done <= 1'b0;
    end else begin
      job_q <= job;
      cal_engine_done <= (job_cnt == 4'h1) && !slow;
      if ((job & ~job_q) != 3'h0) begin
        job_cnt <= 4'h6;
      end else if (job_cnt != 4'h0) begin
        job_cnt <= job_cnt - 4'h1;
      end
    end
  end
  // sensor traffic every eight cycles; relock some cycles after each restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_cnt <= 3'h0;
      sensor_xfer <= 1'b0;
      lock_cnt <= 4'hc;
      baud_locked <= 1'b0;
    end else begin
      xfer_cnt <= xfer_cnt + 3'h1;
      sensor_xfer <= (xfer_cnt == 3'h0);
      if (baud_restart) begin
        lock_cnt <= 4'hc;
        baud_locked <= 1'b0;
      end else if (lock_cnt != 4'h0) begin
        lock_cnt <= lock_cnt - 4'h1;
      end else begin
        baud_locked <= 1'b1;
      end
    end
  end
endmodule

// *** verification/tcs_top_test.sv ***
`timescale 1ns/1ps
module tcs_top_test;
  import tcs_pkg::*;
  typedef struct packed {logic [7:0] sw; logic cfg; logic sens; logic [2:0] cat;} tcs_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, baud_restart;
  logic [7:0] paddr, sw;
  logic [31:0] pwdata, prdata, rd;
  logic band, done, cfg, locked, sens, xfer, frame, slow, err;
  tcs_led_t leds;
  tcs_out_t ctl;
  int num_errors = 0, n_checks = 0, cyc = 0, n_rst = 0, hi, ri, gr, k, n;
  // red: 0 dark, 1 to 3 flashes per burst, 4 solid; row 3 also checks one flash beats three
  tcs_row_t rows [7] = '{'{8'h7f, 1'h1, 1'h1, 3'h0}, '{8'h08, 1'h1, 1'h1, 3'h0},
    '{8'h80, 1'h1, 1'h1, 3'h1}, '{8'h00, 1'h1, 1'h0, 3'h1}, '{8'h01, 1'h1, 1'h0, 3'h3},
    '{8'hff, 1'h0, 1'h1, 3'h4}, '{8'h01, 1'h1, 1'h1, 3'h0}};

  tcs_top #(.JOB_LIMIT(50), .ZERO_WINDOW(200), .LED_SLOT(4)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .address_switch_bank(sw), .pressure_in_band(band),
    .cal_engine_done(done), .factory_cfg_valid(cfg), .baud_locked(locked), .sensor_link_ok(sens),
    .sensor_xfer(xfer), .frame_for_me(frame), .baud_restart(baud_restart), .leds(leds), .ctl(ctl),
    .irq(irq));
  tcs_far_model far (.pclk(pclk), .presetn(presetn), .job({ctl.restore_flag, ctl.span_flag, ctl.zero_flag}),
    .slow(slow), .baud_restart(baud_restart), .cal_engine_done(done), .sensor_xfer(xfer),
    .baud_locked(locked));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // hang guard and restart pulse count, sampled mid-cycle where outputs have settled
  always @(negedge pclk) begin
    cyc++;
    n_rst += (baud_restart === 1'b1);
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: the bench's cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task meas;
    logic p;
    hi = 0;
    ri = 0;
    gr = 0;
    // one extra edge so the first sample has a true predecessor
    @(posedge pclk);
    p = leds.red;
    repeat (120) begin
      @(posedge pclk);
      hi += (leds.red === 1'b1);
      ri += (leds.red === 1'b1 && !p);
      gr += (leds.green === 1'b1);
      p = leds.red;
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, band, frame, slow} = '0;
    {presetn, cfg, sens, sw} = {3'h3, 8'h7f}; // shipped switch setting
    repeat (16) @(posedge pclk);
    chk("rst_ctl", 0, ctl);
    chk("rst_restart", 1, baud_restart);
    presetn <= 1'b1;
    // table: switch decode, range and red priority
    foreach (rows[i]) begin
      k = n_rst;
      @(posedge pclk);
      {sw, cfg, sens} <= {rows[i].sw, rows[i].cfg, rows[i].sens};
      repeat (30) @(posedge pclk);
      chk("restart_count", 1, n_rst - k);
      meas();
      chk("red_mode", rows[i].cat, hi == 120 ? 4 : (ri % 3 != 0) ? 7 : ri / 3);
      if (i == 0) chk("green_active", 1, gr > 0);
    end
    // span without zero, with interrupt masked then unmasked
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_IRQ_STAT, 32'h3f);
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (20) @(posedge pclk);
    chk("span_refused", 0, ctl.span_flag);
    chk("irq_masked", 0, irq);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("refused_event", 1, rd[EV_REFUSED]);
    apb(1'b1, OFS_IRQ_MASK, 32'h3f);
    repeat (2) @(posedge pclk);
    chk("irq_raised", 1, irq);
    apb(1'b1, OFS_IRQ_STAT, 32'h3f);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 0, irq);
    // zero out of band, zero in band, then span inside the window
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    chk("zero_bad", 0, ctl.zero_flag);
    band <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    chk("zero_ok", 1, ctl.zero_flag);
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (20) @(posedge pclk);
    chk("span_ok", 1, ctl.span_flag);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("span_event", 1, rd[EV_SPAN_DONE]);
    // span again once the zero has gone stale
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (250) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (20) @(posedge pclk);
    chk("span_stale", 0, ctl.span_flag);
    // restore with a silent engine ends at the job limit
    slow <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'hc);
    @(negedge pclk);
    chk("restore_busy", 1, ctl.restore_busy);
    chk("coeff_set", 1, ctl.coeff_sel);
    n = 0;
    while (ctl.restore_busy === 1'b1 && n < 80) begin
      @(negedge pclk);
      n++;
    end
    chk("restore_in_time", 1, n >= 48 && n <= 53);
    chk("restore_ok", 1, ctl.restore_flag);
    chk("restore_coeff", 0, ctl.coeff_sel);
    // reinit states with good password
    apb(1'b1, OFS_PASSWORD, PASSWORD_RST);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, OFS_SVC, (s << 8) | 32'h2);
      @(negedge pclk);
      chk("reinit_pulse", s == 0 ? 1 : s == 1 ? 2 : 0, {ctl.reinit_warm, ctl.reinit_cold});
      apb(1'b0, OFS_SVC_RESULT, 32'h0);
      chk("reinit_result", s < 2 ? 2 : 4, rd);
    end
    // comm control with bad, then good password
    apb(1'b1, OFS_PASSWORD, ~PASSWORD_RST);
    apb(1'b1, OFS_SVC, 32'h11);
    apb(1'b0, OFS_SVC_RESULT, 32'h0);
    chk("dcc_bad_pw", 4, rd);
    chk("dcc_kept", 0, ctl.dcc_disabled);
    apb(1'b1, OFS_PASSWORD, PASSWORD_RST);
    apb(1'b1, OFS_DCC_MIN, 32'h5);
    apb(1'b1, OFS_SVC, 32'h11);
    apb(1'b0, OFS_SVC_RESULT, 32'h0);
    chk("dcc_ok", 1, rd);
    chk("dcc_off", 1, ctl.dcc_disabled);
    apb(1'b0, OFS_DCC_MIN, 32'h0);
    chk("dcc_minutes", 5, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 1, err);
    // yellow only after a frame for this node
    chk("yellow_idle", 0, leds.yellow);
    frame <= 1'b1;
    @(posedge pclk);
    frame <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("yellow_frame", 1, leds.yellow);
    test_done();
  end
endmodule
